// ==== dv/sample_pulse_detect_clamp_ctrl_bench.sv ====
// Self-checking bench for the sample-pulse detect and clamp control block.
// Assumes the scanner controller model owns the two sample pins.
`timescale 1ns/1ps
`default_nettype none
module sample_pulse_detect_clamp_ctrl_bench;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        vsp;
    logic        rsp;
    logic        timingSample;
    logic        clampSw;
    logic [2:0]  bufs;
    logic [31:0] rdat;
    logic        rerr;
    int          fail_count = 0;
    int          checks = 0;
    int          cyc = 0;
    always #50 mclk = ~mclk;
    spdc_scan_ctrl ctrl_u (.mclk(mclk), .videoSamplePin(vsp), .resetSamplePin(rsp));
    spdc_top dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .videoSamplePin(vsp), .resetSamplePin(rsp),
        .timingSample(timingSample), .levelClampSwitch(clampSw),
        .topReferenceBufEn(bufs[2]), .bottomReferenceBufEn(bufs[1]),
        .midReferenceBufEn(bufs[0]));
    task automatic close_out;
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", {31'h0, pready}, 32'h1);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, rdat, exp);
    endtask
    task automatic t_reset;
        rdchk(spdc_pkg::ADDR_POWER_DOWN, 32'h00, "pd reset");
        rdchk(spdc_pkg::ADDR_TIMING_CLAMP, 32'h20, "tc reset");
        rdchk(spdc_pkg::ADDR_MODE, 32'h00, "mode reset");
        chk("bufs reset", {29'h0, bufs}, 32'h7);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped err", {31'h0, rerr}, 32'h1);
        chk("unmapped data", rdat, 32'h0);
    endtask
    task automatic t_power;
        logic [10:0] tb [4] = '{11'h07f, 11'h120, 11'h640, 11'h700};
        foreach (tb[i]) begin
            xfer(1'b1, spdc_pkg::ADDR_POWER_DOWN, {24'h0, tb[i][7:0]});
            repeat (2) @(posedge mclk);
            chk("bufs", {29'h0, bufs}, {29'h0, tb[i][10:8]});
            rdchk(spdc_pkg::ADDR_POWER_DOWN, {24'h0, tb[i][7:0] & 8'h7f}, "pd back");
        end
        xfer(1'b1, 8'h40, 32'hff);
        rdchk(spdc_pkg::ADDR_POWER_DOWN, 32'h0, "pd kept");
    endtask
    task automatic pin(input logic v, input logic r, input logic ts, input logic cl);
        ctrl_u.drive(v, r, 2);
        @(posedge mclk);
        #1;
        chk("timing level", {31'h0, timingSample}, {31'h0, ts});
        chk("clamp switch", {31'h0, clampSw}, {31'h0, cl});
    endtask
    task automatic t_clamp;
        pin(1'b0, 1'b1, 1'b0, 1'b1);
        pin(1'b0, 1'b0, 1'b0, 1'b0);
        xfer(1'b1, spdc_pkg::ADDR_TIMING_CLAMP, 32'h60);
        pin(1'b0, 1'b1, 1'b0, 1'b0);
        pin(1'b1, 1'b1, 1'b1, 1'b1);
        rdchk(spdc_pkg::ADDR_STATUS, 32'h0f, "status");
        pin(1'b1, 1'b0, 1'b1, 1'b0);
        xfer(1'b1, spdc_pkg::ADDR_TIMING_CLAMP, 32'h1f);
        pin(1'b0, 1'b1, 1'b0, 1'b0);
        pin(1'b1, 1'b1, 1'b1, 1'b0);
        xfer(1'b1, spdc_pkg::ADDR_MODE, 32'h01);
        xfer(1'b1, spdc_pkg::ADDR_TIMING_CLAMP, 32'h00);
        pin(1'b0, 1'b1, 1'b0, 1'b0);
        pin(1'b1, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic edge_run(input logic pol, input logic [2:0] d);
        int n;
        int hits;
        xfer(1'b1, spdc_pkg::ADDR_TIMING_CLAMP, {27'h0, pol, d, 1'b1});
        ctrl_u.drive(!pol, 1'b0, 12);
        ctrl_u.drive(pol, 1'b0, 2);
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (timingSample !== 1'b1 && n < 16);
        chk("pulse delay", n, 32'(d) + 1);
        @(posedge mclk);
        #1;
        chk("pulse width", {31'h0, timingSample}, 32'h0);
        ctrl_u.drive(!pol, 1'b0, 2);
        hits = 0;
        repeat (12) begin
            @(posedge mclk);
            #1;
            hits += int'(timingSample !== 1'b0);
        end
        chk("wrong edge", hits, 0);
    endtask
    task automatic t_detect;
        logic [2:0] dl [3] = '{3'h0, 3'h3, 3'h7};
        for (int p = 0; p < 2; p++) begin
            foreach (dl[i]) begin
                edge_run(p[0], dl[i]);
            end
        end
    endtask
    task automatic t_compat_clamp;
        int hits;
        logic [7:0] md [2] = '{8'h01, 8'h05};
        foreach (md[i]) begin
            xfer(1'b1, spdc_pkg::ADDR_MODE, {24'h0, md[i]});
            xfer(1'b1, spdc_pkg::ADDR_TIMING_CLAMP, 32'h60);
            ctrl_u.drive(1'b0, 1'b0, 12);
            ctrl_u.drive(1'b1, 1'b0, 2);
            hits = 0;
            repeat (14) begin
                @(posedge mclk);
                #1;
                hits += int'(clampSw !== 1'b0);
            end
            chk("pixel clamp", hits, 1);
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_power();
        t_clamp();
        t_detect();
        t_compat_clamp();
        close_out();
    end
endmodule
bind spdc_top spdc_props chk_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .videoSamplePin(videoSamplePin), .resetSamplePin(resetSamplePin),
    .timingSample(timingSample), .levelClampSwitch(levelClampSwitch),
    .topReferenceBufEn(topReferenceBufEn), .bottomReferenceBufEn(bottomReferenceBufEn),
    .midReferenceBufEn(midReferenceBufEn));
`default_nettype wire

// ==== dv/spdc_props.sv ====
// Port-level checks for the sample-pulse detect and clamp control block.
// Assumes it is bound to spdc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module spdc_props (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        videoSamplePin,
    input wire logic        resetSamplePin,
    input wire logic        timingSample,
    input wire logic        levelClampSwitch,
    input wire logic        topReferenceBufEn,
    input wire logic        bottomReferenceBufEn,
    input wire logic        midReferenceBufEn
);
    logic [7:0]  pdSh;
    logic [7:0]  tcSh;
    logic [7:0]  modeSh;
    logic [3:0]  age;
    logic [10:0] hist;
    logic        wr;
    logic        compat;
    logic        steady;
    logic        pulseExp;
    logic [2:0]  dl;
    assign wr = psel && penable && pready && pwrite && !pslverr;
    assign compat = modeSh[0];
    assign steady = age >= 4'h4;
    assign dl = tcSh[3:1];
    // The pulse falls due when the pin history shows the chosen edge dl+2 clocks back.
    assign pulseExp = tcSh[4] ? (hist[2+dl] && !hist[3+dl]) : (!hist[2+dl] && hist[3+dl]);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pdSh <= spdc_pkg::PD_RESET;
            tcSh <= spdc_pkg::TC_RESET;
            modeSh <= spdc_pkg::MODE_RESET;
        end else if (wr && paddr == spdc_pkg::ADDR_POWER_DOWN) begin
            pdSh <= pwdata[7:0];
        end else if (wr && paddr == spdc_pkg::ADDR_TIMING_CLAMP) begin
            tcSh <= pwdata[7:0];
        end else if (wr && paddr == spdc_pkg::ADDR_MODE) begin
            modeSh <= pwdata[7:0];
        end
    end
    // Pin checks wait until the synchronisers and delay line hold only new-setup data.
    always_ff @(posedge mclk) begin
        if (!rst_n || wr) begin
            age <= 4'h0;
        end else if (age != 4'hf) begin
            age <= age + 4'h1;
        end
    end
    always_ff @(posedge mclk) begin
        hist <= {hist[9:0], videoSamplePin};
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error response");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_conv_buf_off: assert property (topReferenceBufEn == !$past(pdSh[5]) && bottomReferenceBufEn == !$past(pdSh[5]))
        else $error("top or bottom buffer wrong");
    a_mid_buf_off: assert property (midReferenceBufEn == !$past(pdSh[6]))
        else $error("mid buffer wrong");
    a_clamp_src_zero: assert property (steady && !compat && tcSh[5] && !tcSh[6] |-> levelClampSwitch == $past(resetSamplePin, 3))
        else $error("clamp not following reset pin");
    a_clamp_src_one: assert property (steady && !compat && tcSh[5] && tcSh[6] |-> levelClampSwitch == (hist[2] && $past(resetSamplePin, 3)))
        else $error("clamp not gated by video pin");
    a_clamp_off: assert property (steady && !tcSh[5] |-> !levelClampSwitch)
        else $error("clamp while disabled");
    a_direct_level: assert property (steady && !(compat && tcSh[0]) |-> timingSample == hist[2])
        else $error("timing level not forwarded");
    a_detect_pulse: assert property (age >= 4'hc && compat && tcSh[0] |-> timingSample == pulseExp)
        else $error("detect pulse misplaced");
endmodule
`default_nettype wire

// ==== dv/spdc_scan_ctrl.sv ====
// Model of the scanner timing controller that drives both sample pins.
// Assumes callers run in the bench and share mclk with the block.
`timescale 1ns/1ps
`default_nettype none
module spdc_scan_ctrl (
    input  wire logic mclk,
    output var logic  videoSamplePin,
    output var logic  resetSamplePin
);
    initial begin
        videoSamplePin = 1'b0;
        resetSamplePin = 1'b0;
    end
    // Shorter holds would let the synchronous detector miss a level.
    task automatic drive(input logic v, input logic r, input int hold);
        @(posedge mclk);
        videoSamplePin <= v;
        resetSamplePin <= r;
        repeat (hold < 2 ? 2 : hold) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ==== src/spdc_det_if.sv ====
// Signals between the control top and the edge detector with delay line.
// Assumes both ends run on the same master clock.
`timescale 1ns/1ps
`default_nettype none
interface spdc_det_if;
    logic                              videoLevel;
    logic                              riseSel;
    logic                              detectOn;
    logic [spdc_pkg::TC_DELAY_W-1:0]   delaySel;
    logic                              timingPulse;
    logic                              pixelTick;

    modport ctrl (
        output videoLevel,
        output riseSel,
        output detectOn,
        output delaySel,
        input  timingPulse,
        input  pixelTick
    );

    modport det (
        input  videoLevel,
        input  riseSel,
        input  detectOn,
        input  delaySel,
        output timingPulse,
        output pixelTick
    );
endinterface
`default_nettype wire

// ==== src/spdc_edge_delay.sv ====
// Edge detector for the synchronised video-sample level and a short
// delay line that places the internal timing pulse.
// Assumes videoLevel is already synchronised to mclk.
`timescale 1ns/1ps
`default_nettype none
module spdc_edge_delay (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    spdc_det_if.det    det
);
    logic                                prevLevel;
    logic                                riseHit;
    logic                                fallHit;
    logic                                edgeHit;
    logic [spdc_pkg::DELAY_MAX-1:0]      delayLine;
    logic [spdc_pkg::DELAY_MAX:0]        taps;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prevLevel <= 1'b0;
        end else begin
            prevLevel <= det.videoLevel;
        end
    end

    assign riseHit = det.videoLevel & ~prevLevel;
    assign fallHit = ~det.videoLevel & prevLevel;
    assign edgeHit = det.riseSel ? riseHit : fallHit;

    // A shift line rather than a counter, so edges closer together than
    // the delay each still produce their own pulse.
    always_ff @(posedge mclk) begin
        if (!rst_n || !det.detectOn) begin
            delayLine <= '0;
        end else begin
            delayLine <= {delayLine[spdc_pkg::DELAY_MAX-2:0], edgeHit};
        end
    end

    assign taps            = {delayLine, edgeHit};
    assign det.timingPulse = det.detectOn & taps[det.delaySel];
    assign det.pixelTick   = det.detectOn ? det.timingPulse : riseHit;
endmodule
`default_nettype wire

// ==== src/spdc_pkg.sv ====
// Shared constants for the sample-pulse detect and clamp control block.
// Assumes a 32-bit APB slave with byte addresses formed as four times
// the register index.
package spdc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;

    // Register indices; the bus byte address is four times the index.
    localparam logic [5:0] IDX_POWER_DOWN   = 6'h07;
    localparam logic [5:0] IDX_TIMING_CLAMP = 6'h08;
    localparam logic [5:0] IDX_STATUS       = 6'h09;
    localparam logic [5:0] IDX_MODE         = 6'h0a;

    localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN   = {IDX_POWER_DOWN, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_TIMING_CLAMP = {IDX_TIMING_CLAMP, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS       = {IDX_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MODE         = {IDX_MODE, 2'b00};

    // Timing and clamp setup fields.
    localparam int unsigned TC_DETECT_EN = 0;
    localparam int unsigned TC_DELAY_LSB = 1;
    localparam int unsigned TC_DELAY_W   = 3;
    localparam int unsigned TC_POLARITY  = 4;
    localparam int unsigned TC_CLAMP_EN  = 5;
    localparam int unsigned TC_CLAMP_SRC = 6;

    // Power-down setup fields.
    localparam int unsigned PD_CONV_REF = 5;
    localparam int unsigned PD_MID_REF  = 6;

    // Mode register fields.
    localparam int unsigned MODE_COMPAT  = 0;
    localparam int unsigned MODE_REF_LSB = 1;
    localparam int unsigned MODE_REF_W   = 2;

    // Status register fields.
    localparam int unsigned ST_VIDEO  = 0;
    localparam int unsigned ST_RESET  = 1;
    localparam int unsigned ST_CLAMP  = 2;
    localparam int unsigned ST_TIMING = 3;
    localparam int unsigned ST_WAIT   = 4;

    localparam logic [REG_W-1:0] TC_RESET   = 8'h20;
    localparam logic [REG_W-1:0] PD_RESET   = 8'h00;
    localparam logic [REG_W-1:0] MODE_RESET = 8'h00;
    localparam logic [REG_W-1:0] SETUP_MASK = 8'h7f;
    localparam logic [REG_W-1:0] MODE_MASK  = 8'h07;

    // Longest programmable delay in master clock periods.
    localparam int unsigned DELAY_MAX = 7;

    typedef enum logic [0:0] {
        CLAMP_IDLE = 1'b0,
        CLAMP_WAIT = 1'b1
    } spdc_clamp_state_t;

endpackage

// ==== src/spdc_top.sv ====
// Sample-pulse detect and reset-level clamp control with reference
// buffer power-down bits, reached over a 32-bit APB slave.
// Assumes the sample pins come from an outside timing controller and
// are asynchronous to mclk; everything else runs on mclk.
//
// Contract
// - Conversion reference off disables top, bottom buffers.
// - Mid reference off disables the mid buffer.
// - Detect enable ignored outside compatibility mode.
// - Compat without detect forwards video level directly.
// - Compat with detect forwards internal pulse instead.
// - Pulse delayed by detect_delay clocks; resets zero.
// - Delay ignored unless compat and detect enabled.
// - Polarity zero falling edges, one rising edges.
// - Polarity ignored unless compat and detect enabled.
// - Clamp only while clamp enable set; resets one.
// - Compat mode clamps every pixel at reference timing; a new tick during the wait restarts it, dropping the pending clamp.
// - Clamp source select ignored in compatibility mode.
// - Source zero: switch follows reset-sample level.
// - Source one: switch closes on both pins high.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module spdc_top (
    input  wire logic                            mclk,
    input  wire logic                            rst_n,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [spdc_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [spdc_pkg::DATA_W-1:0]     pwdata,
    output logic      [spdc_pkg::DATA_W-1:0]     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            videoSamplePin,
    input  wire logic                            resetSamplePin,
    output logic                                 timingSample,
    output logic                                 levelClampSwitch,
    output logic                                 topReferenceBufEn,
    output logic                                 bottomReferenceBufEn,
    output logic                                 midReferenceBufEn
);

    // Register storage.
    logic [spdc_pkg::REG_W-1:0]          timingClampSetup;
    logic [spdc_pkg::REG_W-1:0]          powerDownSetup;
    logic [spdc_pkg::REG_W-1:0]          modeSetup;

    // Pin synchronisers.
    logic                                videoMeta;
    logic                                videoSync;
    logic                                resetMeta;
    logic                                resetSync;

    // Decoded controls.
    logic                                compatNibbleMode;
    logic                                sampleDetectEn;
    logic                                edgePolarity;
    logic                                clampEnable;
    logic                                clampSourceSel;
    logic [spdc_pkg::TC_DELAY_W-1:0]     detectDelay;
    logic [spdc_pkg::MODE_REF_W-1:0]     sampleRefTiming;
    logic                                detectActive;

    // Compatibility-mode clamp sequencing.
    spdc_pkg::spdc_clamp_state_t         clampState;
    spdc_pkg::spdc_clamp_state_t         next_clampState;
    logic [spdc_pkg::MODE_REF_W-1:0]     clampCount;
    logic                                compatClampPulse;
    logic                                next_clampSwitch;

    // Bus decode.
    logic                                setupPhase;
    logic                                accessDone;
    logic                                writeTake;
    logic [spdc_pkg::REG_W-1:0]          readValue;
    logic                                addrHit;

    spdc_det_if detBus ();

    function automatic logic mapped(input logic [spdc_pkg::ADDR_W-1:0] addr);
        return (addr == spdc_pkg::ADDR_POWER_DOWN)   ||
               (addr == spdc_pkg::ADDR_TIMING_CLAMP) ||
               (addr == spdc_pkg::ADDR_STATUS)       ||
               (addr == spdc_pkg::ADDR_MODE);
    endfunction

    // Pin synchronisers: the first stage feeds only the second.
    // The pins are asynchronous to mclk, so two flops guard against metastability.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            videoMeta <= 1'b0;
            videoSync <= 1'b0;
        end else begin
            videoMeta <= videoSamplePin;
            videoSync <= videoMeta;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            resetMeta <= 1'b0;
            resetSync <= 1'b0;
        end else begin
            resetMeta <= resetSamplePin;
            resetSync <= resetMeta;
        end
    end

    // Field decode.
    // Each control is a fixed slice of its register, so decode is plain wiring.
    assign compatNibbleMode = modeSetup[spdc_pkg::MODE_COMPAT];
    assign sampleRefTiming  = modeSetup[spdc_pkg::MODE_REF_LSB +: spdc_pkg::MODE_REF_W];
    assign sampleDetectEn   = timingClampSetup[spdc_pkg::TC_DETECT_EN];
    assign detectDelay      = timingClampSetup[spdc_pkg::TC_DELAY_LSB +: spdc_pkg::TC_DELAY_W];
    assign edgePolarity     = timingClampSetup[spdc_pkg::TC_POLARITY];
    assign clampEnable      = timingClampSetup[spdc_pkg::TC_CLAMP_EN];
    assign clampSourceSel   = timingClampSetup[spdc_pkg::TC_CLAMP_SRC];

    // Detection, delay and polarity only count in compatibility mode.
    assign detectActive = compatNibbleMode & sampleDetectEn;

    assign detBus.videoLevel = videoSync;
    assign detBus.riseSel    = detectActive & edgePolarity;
    assign detBus.detectOn   = detectActive;
    assign detBus.delaySel   = detectActive ? detectDelay : '0;

    spdc_edge_delay edgeDelay (
        .mclk  (mclk),
        .rst_n (rst_n),
        .det   (detBus.det)
    );

    // Timing path to the timing controller.
    // Registered so the timing controller never sees a decode glitch.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timingSample <= 1'b0;
        end else if (detectActive) begin
            timingSample <= detBus.timingPulse;
        end else begin
            timingSample <= videoSync;
        end
    end

    // Compatibility-mode clamp: one clamp pulse per pixel, placed
    // sampleRefTiming clocks after the pixel tick. A new tick while
    // waiting restarts the wait, so a pixel never gets two clamps.
    always_comb begin
        next_clampState  = clampState;
        compatClampPulse = 1'b0;
        case (clampState)
            spdc_pkg::CLAMP_IDLE: begin
                if (detBus.pixelTick) begin
                    if (sampleRefTiming == '0) begin
                        compatClampPulse = 1'b1;
                    end else begin
                        next_clampState = spdc_pkg::CLAMP_WAIT;
                    end
                end
            end
            spdc_pkg::CLAMP_WAIT: begin
                if (detBus.pixelTick) begin
                    next_clampState = spdc_pkg::CLAMP_WAIT;
                end else if (clampCount == '0) begin
                    compatClampPulse = 1'b1;
                    next_clampState  = spdc_pkg::CLAMP_IDLE;
                end
            end
            default: begin
                next_clampState = spdc_pkg::CLAMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !compatNibbleMode) begin
            clampState <= spdc_pkg::CLAMP_IDLE;
        end else begin
            clampState <= next_clampState;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clampCount <= '0;
        end else if (detBus.pixelTick) begin
            clampCount <= sampleRefTiming - 2'h1;
        end else if (clampState == spdc_pkg::CLAMP_WAIT && clampCount != '0) begin
            clampCount <= clampCount - 2'h1;
        end
    end

    // Clamp switch selection.
    // Compatibility mode is tested before the source select, which it overrides.
    always_comb begin
        if (!clampEnable) begin
            next_clampSwitch = 1'b0;
        end else if (compatNibbleMode) begin
            next_clampSwitch = compatClampPulse;
        end else if (clampSourceSel) begin
            next_clampSwitch = resetSync & videoSync;
        end else begin
            next_clampSwitch = resetSync;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            levelClampSwitch <= 1'b0;
        end else begin
            levelClampSwitch <= next_clampSwitch;
        end
    end

    // Reference buffer enables.
    // A buffer follows its power-off bit one cycle after the write lands.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            topReferenceBufEn    <= 1'b1;
            bottomReferenceBufEn <= 1'b1;
            midReferenceBufEn    <= 1'b1;
        end else begin
            topReferenceBufEn    <= ~powerDownSetup[spdc_pkg::PD_CONV_REF];
            bottomReferenceBufEn <= ~powerDownSetup[spdc_pkg::PD_CONV_REF];
            midReferenceBufEn    <= ~powerDownSetup[spdc_pkg::PD_MID_REF];
        end
    end

    // APB slave: the answer is prepared in the setup cycle, so every
    // access phase lasts exactly one cycle and the outputs stay flops.
    // Unmapped addresses answer with an error and change no register.
    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & pready;
    assign writeTake  = accessDone & pwrite & ~pslverr;
    assign addrHit    = mapped(paddr);

    always_comb begin
        case (paddr)
            spdc_pkg::ADDR_POWER_DOWN:   readValue = powerDownSetup;
            spdc_pkg::ADDR_TIMING_CLAMP: readValue = timingClampSetup;
            spdc_pkg::ADDR_MODE:         readValue = modeSetup;
            spdc_pkg::ADDR_STATUS: begin
                readValue                       = '0;
                readValue[spdc_pkg::ST_VIDEO]   = videoSync;
                readValue[spdc_pkg::ST_RESET]   = resetSync;
                readValue[spdc_pkg::ST_CLAMP]   = levelClampSwitch;
                readValue[spdc_pkg::ST_TIMING]  = timingSample;
                readValue[spdc_pkg::ST_WAIT]    = (clampState == spdc_pkg::CLAMP_WAIT);
            end
            default:                     readValue = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (setupPhase) begin
            pready  <= 1'b1;
            pslverr <= ~addrHit;
            prdata  <= (pwrite || !addrHit) ? '0
                     : {{(spdc_pkg::DATA_W-spdc_pkg::REG_W){1'b0}}, readValue};
        end else if (accessDone) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
    end

    // The top setup bit is never stored, so it reads back as zero.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timingClampSetup <= spdc_pkg::TC_RESET;
        end else if (writeTake && paddr == spdc_pkg::ADDR_TIMING_CLAMP) begin
            timingClampSetup <= pwdata[spdc_pkg::REG_W-1:0] & spdc_pkg::SETUP_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            powerDownSetup <= spdc_pkg::PD_RESET;
        end else if (writeTake && paddr == spdc_pkg::ADDR_POWER_DOWN) begin
            powerDownSetup <= pwdata[spdc_pkg::REG_W-1:0] & spdc_pkg::SETUP_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            modeSetup <= spdc_pkg::MODE_RESET;
        end else if (writeTake && paddr == spdc_pkg::ADDR_MODE) begin
            modeSetup <= pwdata[spdc_pkg::REG_W-1:0] & spdc_pkg::MODE_MASK;
        end
    end

endmodule
`default_nettype wire
